// [verilog/seq_pkg.sv]
// Constants, state codes and setting limits of the auto reset sequencer.
package seq_pkg;
  localparam int SECOND_MS = 1000;
  localparam int CLK_KHZ = 125000;
  localparam int CYCLES_PER_SEC = SECOND_MS * CLK_KHZ;
  localparam int SEC_W = 13;
  localparam int ATT_W = 4;
  localparam int OUT_W = 17;
  localparam int N_TRIP = 8;
  localparam logic [SEC_W-1:0] DELAY_MAX_S = 13'h1c20;
  localparam logic [ATT_W-1:0] ATT_MAX = 4'ha;
  localparam logic [SEC_W-1:0] TF_MIN_S = 13'h0078;
  localparam logic [SEC_W-1:0] TF_MAX_S = 13'h1c20;
  localparam logic DEF_ENABLE = 1'h0;
  localparam logic [SEC_W-1:0] DEF_DELAY_S = 13'h0000;
  localparam logic [ATT_W-1:0] DEF_ATT = 4'h0;
  localparam logic [SEC_W-1:0] DEF_TF_S = 13'h0258;
  localparam logic [ATT_W-1:0] RST_ATT = 4'h0;
  localparam logic [SEC_W-1:0] RST_SEC = 13'h0000;
  localparam logic [OUT_W-1:0] RST_LAG = 17'h00000;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WAIT = 4'b0010,
    ST_RUN = 4'b0100,
    ST_OVER = 4'b1000
  } seq_state_t;
  localparam logic [1:0] MODE_PROG = 2'h0;
  localparam logic [1:0] MODE_TWO = 2'h1;
  localparam logic [1:0] MODE_THREE = 2'h2;
  localparam logic [1:0] MODE_NET = 2'h3;
  localparam logic [1:0] OUT_OFF = 2'h0;
  localparam logic [1:0] OUT_PEND = 2'h1;
  localparam logic [1:0] OUT_OVER = 2'h2;
  localparam logic [1:0] OUT_ACTIVE = 2'h3;
endpackage

// [verilog/tick_if.sv]
// Second tick carrier between the timebase and the sequencer.
`timescale 1ns/1ps
interface tick_if;
  logic tick;
  logic resync;
  modport src(output tick, input resync);
  modport dst(input tick, output resync);
endinterface

// [verilog/second_timebase.sv]
// One pulse per second derived from mclk.
`timescale 1ns/1ps
module second_timebase
  import seq_pkg::*;
#(
  parameter int CYCLES = CYCLES_PER_SEC
) (
  input wire logic mclk,
  input wire logic rst_b,
  tick_if.src tb
);
  localparam int CW = $clog2(CYCLES);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } tb_state_t;
  tb_state_t s;
  tb_state_t n;

  always_comb begin
    n = s;
    n.tick = 1'b0;
    // Restarting at power-up keeps the first second after it a whole second.
    if (tb.resync) begin
      n.cnt = '0;
    end else if (s.cnt == CW'(CYCLES - 1)) begin
      n.cnt = '0;
      n.tick = 1'b1;
    end else begin
      n.cnt = s.cnt + CW'(1);
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign tb.tick = s.tick;
endmodule

// [verilog/auto_reset_seq.sv]
// Auto reset sequencer: clears selected trips, retries the start and times the trip-free run.
`timescale 1ns/1ps
module auto_reset_seq
  import seq_pkg::*;
#(
  parameter int SEC_CYCLES = CYCLES_PER_SEC,
  parameter int NT = N_TRIP
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic enable,
  input wire logic [SEC_W-1:0] delay_set,
  input wire logic [ATT_W-1:0] attempts_set,
  input wire logic [SEC_W-1:0] trip_free_set,
  input wire logic [NT-1:0] trip_sel,
  input wire logic [1:0] ctrl_mode,
  input wire logic hand_sel,
  input wire logic [NT-1:0] trip_src,
  input wire logic start_cmd,
  input wire logic stop_cmd,
  input wire logic ext_reset,
  input wire logic power_up,
  input wire logic [OUT_W-1:0] outage_s,
  input wire logic start_saved,
  input wire logic [7:0] dout_sel,
  output logic [ATT_W-1:0] attempts_left,
  output logic [ATT_W-1:0] attempt_num,
  output logic [SEC_W-1:0] delay_left,
  output logic [SEC_W-1:0] trip_free_left,
  output logic pending,
  output logic exceeded,
  output logic trip_clear,
  output logic restart_req,
  output logic trip_reset,
  output logic [3:0] dout
);
  typedef struct packed {
    seq_state_t state;
    logic [ATT_W-1:0] att;
    logic [ATT_W-1:0] num;
    logic [SEC_W-1:0] dly;
    logic [SEC_W-1:0] tf;
    logic [OUT_W-1:0] lag;
    logic start_q;
    logic rst_q;
    logic clr;
    logic rst_ev;
    logic [3:0] dout;
  } seq_t;

  seq_t s;
  seq_t n;
  tick_if tb();
  logic [ATT_W-1:0] att_cl;
  logic [SEC_W-1:0] dly_cl;
  logic [SEC_W-1:0] tf_cl;
  logic [OUT_W-1:0] budget;
  logic reset_evt;
  logic trip_act;
  logic tick_eff;
  logic two_drop;
  logic stop_abort;
  logic wire3;
  logic [3:0] next_dout;

  second_timebase #(.CYCLES(SEC_CYCLES)) u_timebase (
    .mclk(mclk),
    .rst_b(rst_b),
    .tb(tb.src)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Settings clamped to their legal ranges.
  assign att_cl = (attempts_set > ATT_MAX) ? ATT_MAX : attempts_set;
  assign dly_cl = (delay_set > DELAY_MAX_S) ? DELAY_MAX_S : delay_set;
  assign tf_cl = (trip_free_set < TF_MIN_S) ? TF_MIN_S :
                 (trip_free_set > TF_MAX_S) ? TF_MAX_S : trip_free_set;
  assign budget = OUT_W'(dly_cl) * OUT_W'(att_cl);
  assign wire3 = (ctrl_mode == MODE_THREE) || (ctrl_mode == MODE_NET);
  assign reset_evt = (ctrl_mode == MODE_TWO) ? (start_cmd && !s.start_q)
                                             : (ext_reset && !s.rst_q);
  // The thermal level is deliberately not an input: an overload trip in the
  // selected set is cleared like any other, so a short delay re-trips.
  // The far side drops a trip only at the edge after a clear or reset pulse, so the stale
  // trip is ignored while either pulse stands; otherwise a restart would re-trip at once.
  assign trip_act = (|(trip_src & trip_sel)) && !s.clr && !s.rst_ev;
  assign tick_eff = (s.lag != RST_LAG) || tb.tick;
  assign two_drop = (ctrl_mode == MODE_TWO) && !start_cmd;
  assign stop_abort = wire3 && stop_cmd;
  assign tb.resync = power_up;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer.
  function automatic seq_t reinit(seq_t c, logic [ATT_W-1:0] a);
    seq_t r;
    r = c;
    r.state = ST_IDLE;
    r.att = a;
    r.num = RST_ATT;
    r.dly = RST_SEC;
    r.tf = RST_SEC;
    r.lag = RST_LAG;
    return r;
  endfunction

  always_comb begin
    n = s;
    n.clr = 1'b0;
    n.rst_ev = reset_evt;
    n.start_q = start_cmd;
    n.rst_q = ext_reset;
    n.dout = next_dout;
    if (hand_sel || !enable) begin
      n = reinit(n, att_cl);
    end else if (reset_evt && (s.state != ST_IDLE)) begin
      n = reinit(n, att_cl);
    end else if (power_up && (s.state == ST_WAIT || s.state == ST_RUN)) begin
      if (outage_s > budget) begin
        n.state = ST_OVER;
        n.lag = RST_LAG;
      end else if (wire3 && !start_saved) begin
        n = reinit(n, att_cl);
      end else begin
        n.lag = outage_s;
      end
    end else begin
      unique case (s.state)
        ST_IDLE: begin
          n.att = att_cl;
          if (trip_act) begin
            n.state = (att_cl != RST_ATT) ? ST_WAIT : ST_OVER;
            n.dly = dly_cl;
          end
        end
        ST_WAIT: begin
          if (two_drop || stop_abort) begin
            n = reinit(n, att_cl);
          end else if (s.dly == RST_SEC) begin
            n.att = s.att - ATT_W'(1);
            n.num = s.num + ATT_W'(1);
            if (s.lag == RST_LAG) begin
              n.clr = 1'b1;
              n.state = ST_RUN;
              n.tf = tf_cl;
            end else begin
              // Attempts that fell inside the outage are consumed silently.
              n.state = (n.att == RST_ATT) ? ST_OVER : ST_WAIT;
              n.dly = dly_cl;
              n.lag = (n.att == RST_ATT) ? RST_LAG : s.lag;
            end
          end else if (tick_eff) begin
            n.dly = s.dly - SEC_W'(1);
            n.lag = (s.lag != RST_LAG) ? s.lag - OUT_W'(1) : RST_LAG;
          end
        end
        ST_RUN: begin
          if (trip_act) begin
            n.state = (s.att != RST_ATT) ? ST_WAIT : ST_OVER;
            n.dly = dly_cl;
          end else if (s.tf == RST_SEC) begin
            n = reinit(n, att_cl);
          end else if (tick_eff) begin
            n.tf = s.tf - SEC_W'(1);
            n.lag = (s.lag != RST_LAG) ? s.lag - OUT_W'(1) : RST_LAG;
          end
        end
        ST_OVER: begin
          if (stop_cmd) begin
            n = reinit(n, att_cl);
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '{state: ST_IDLE, att: RST_ATT, num: RST_ATT, dly: RST_SEC, tf: RST_SEC,
             lag: RST_LAG, start_q: 1'b0, rst_q: 1'b0, clr: 1'b0, rst_ev: 1'b0,
             dout: 4'h0};
    end else begin
      s <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status routing and outputs.
  for (genvar i = 0; i < 4; i++) begin : g_dout
    always_comb begin
      unique case (dout_sel[2*i +: 2])
        OUT_OFF: next_dout[i] = 1'b0;
        OUT_PEND: next_dout[i] = (s.state == ST_WAIT);
        OUT_OVER: next_dout[i] = (s.state == ST_OVER);
        OUT_ACTIVE: next_dout[i] = (s.state != ST_IDLE);
      endcase
    end
  end

  assign attempts_left = s.att;
  assign attempt_num = s.num;
  assign delay_left = s.dly;
  assign trip_free_left = s.tf;
  assign pending = (s.state == ST_WAIT);
  assign exceeded = (s.state == ST_OVER);
  assign trip_clear = s.clr;
  assign restart_req = s.clr;
  assign trip_reset = s.rst_ev;
  assign dout = s.dout;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  hand_clear_a: assert property (@(posedge mclk) disable iff (!rst_b)
    hand_sel |=> (s.state == ST_IDLE) && (s.att == $past(att_cl)) && (s.tf == RST_SEC))
    else $error("hand mode did not reinitialise");
  two_drop_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (s.state == ST_WAIT) && two_drop && enable && !power_up |=> s.state == ST_IDLE)
    else $error("two-wire start drop did not abandon");
  stop_abort_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (s.state == ST_WAIT) && stop_abort && enable && !power_up |=> s.state == ST_IDLE)
    else $error("stop did not abandon pending retry");
  free_done_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (s.state == ST_RUN) && (s.tf == RST_SEC) && !trip_act && enable && !hand_sel
    && !reset_evt && !power_up |=> (s.state == ST_IDLE) && (s.num == RST_ATT))
    else $error("trip-free end did not reload counters");
  outage_term_a: assert property (@(posedge mclk) disable iff (!rst_b)
    power_up && (s.state == ST_WAIT || s.state == ST_RUN) && (outage_s > budget) && enable
    && !hand_sel && !reset_evt |=> s.state == ST_OVER)
    else $error("long outage did not terminate");
  restart_fire_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (s.state == ST_WAIT) && (s.dly == RST_SEC) && (s.lag == RST_LAG) && enable
    && !hand_sel && !reset_evt && !power_up && !two_drop && !stop_abort
    |=> restart_req && (s.att == $past(s.att) - ATT_W'(1)) && (s.state == ST_RUN))
    else $error("restart not issued at delay zero");
  reset_edge_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (ctrl_mode == MODE_TWO) && $rose(start_cmd) |=> trip_reset)
    else $error("start edge gave no trip reset");
  over_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
    exceeded && !stop_cmd && !reset_evt && !hand_sel && enable |=> exceeded)
    else $error("exhausted state left without reset");
  dout_map_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (dout_sel[3:2] == OUT_PEND) |=> dout[1] == $past(pending))
    else $error("pending not routed to output");
  retrip_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (s.state == ST_RUN) && trip_act && (s.att == RST_ATT) && enable && !hand_sel
    && !reset_evt && !power_up |=> exceeded)
    else $error("re-trip with no attempts left not exhausted");
  restart_c: cover property (@(posedge mclk) disable iff (!rst_b) restart_req);
  exceed_c: cover property (@(posedge mclk) disable iff (!rst_b) $rose(exceeded));
  free_c: cover property (@(posedge mclk) disable iff (!rst_b)
    (s.state == ST_RUN) ##1 (s.state == ST_IDLE));
  catchup_c: cover property (@(posedge mclk) disable iff (!rst_b)
    (s.lag != RST_LAG) && (s.state == ST_WAIT));
endmodule

// [sim/trip_model.sv]
// Model of the trip sources that sit beyond the auto reset sequencer.
`timescale 1ns/1ps
module trip_model (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic fault,
  input wire logic heal,
  input wire logic retrip,
  input wire logic trip_clear,
  input wire logic trip_reset,
  output logic [7:0] trip_src
);
  // A hot overload (retrip) stays set through a clear pulse; only heal or a reset pulse drops it.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      trip_src <= 8'h00;
    end else if (fault) begin
      trip_src <= 8'h01;
    end else if (heal || trip_reset || (trip_clear && !retrip)) begin
      trip_src <= 8'h00;
    end
  end
endmodule

// [sim/auto_reset_seq_tb_top.sv]
// Self-checking bench for the auto reset sequencer.
`timescale 1ns/1ps
module auto_reset_seq_tb_top;
  import seq_pkg::*;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic enable = 1'b1;
  logic [SEC_W-1:0] delay_set = 13'h0001;
  logic [ATT_W-1:0] attempts_set = 4'h2;
  logic [1:0] ctrl_mode = MODE_PROG;
  logic hand_sel = 1'b0;
  logic start_cmd = 1'b0;
  logic stop_cmd = 1'b0;
  logic ext_reset = 1'b0;
  logic power_up = 1'b0;
  logic fault = 1'b0;
  logic heal = 1'b0;
  logic retrip = 1'b0;
  logic start_saved = 1'b0;
  logic [OUT_W-1:0] outage_s = 17'h00000;
  logic [7:0] trip_src;
  logic [ATT_W-1:0] attempts_left, attempt_num;
  logic [SEC_W-1:0] delay_left, trip_free_left;
  logic pending, exceeded, trip_clear, restart_req, trip_reset;
  logic [3:0] dout;
  logic got;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;

  auto_reset_seq #(.SEC_CYCLES(10)) uut (.mclk(mclk), .rst_b(rst_b), .enable(enable),
    .delay_set(delay_set), .attempts_set(attempts_set), .trip_free_set(TF_MIN_S),
    .trip_sel(8'hff), .ctrl_mode(ctrl_mode), .hand_sel(hand_sel), .trip_src(trip_src),
    .start_cmd(start_cmd), .stop_cmd(stop_cmd), .ext_reset(ext_reset),
    .power_up(power_up), .outage_s(outage_s), .start_saved(start_saved),
    .dout_sel({OUT_ACTIVE, OUT_OVER, OUT_PEND, OUT_OFF}), .attempts_left(attempts_left),
    .attempt_num(attempt_num), .delay_left(delay_left), .trip_free_left(trip_free_left),
    .pending(pending), .exceeded(exceeded), .trip_clear(trip_clear),
    .restart_req(restart_req), .trip_reset(trip_reset), .dout(dout));

  trip_model far (.mclk(mclk), .rst_b(rst_b), .fault(fault), .heal(heal), .retrip(retrip),
    .trip_clear(trip_clear), .trip_reset(trip_reset), .trip_src(trip_src));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #4 mclk = ~mclk;
  end

  // The ceiling is well above the longest trip-free wait of the run.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 6000) begin
      fail_count++;
      close_out();
    end
  end

  task check(input string what, input logic [16:0] seen, input logic [16:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // One-cycle strobe: 0 fault, 1 heal, 2 stop, 3 reset input, 4 power return.
  task poke(input int w);
    @(negedge mclk);
    {power_up, ext_reset, stop_cmd, heal, fault} = 5'(1 << w);
    @(negedge mclk);
    {power_up, ext_reset, stop_cmd, heal, fault} = 5'h00;
  endtask

  task wait_ev(input int w, input int n);
    got = 1'b0;
    for (int i = 0; i < n && !got; i++) begin
      @(negedge mclk);
      got = ((w == 0) ? restart_req : trip_reset) === 1'b1;
    end
  endtask

  task trip_up(input logic cure);
    poke(0);
    cyc(3);
    check("pending", 17'(pending), 17'h1);
    if (cure) poke(1);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task t_walk;
    check("reload", 17'(attempts_left), 17'h2);
    trip_up(0);
    cyc(2);
    check("delay", 17'(delay_left), 17'h1);
    check("dout", 17'(dout), 17'h0a);
    wait_ev(0, 40);
    check("restart", 17'(got), 17'h1);
    check("clear", 17'(trip_clear), 17'h1);
    check("left", 17'(attempts_left), 17'h1);
    check("num", 17'(attempt_num), 17'h1);
    check("tf", 17'(trip_free_left), 17'(TF_MIN_S));
    cyc(1260);
    check("num0", 17'(attempt_num), 17'h0);
    check("left2", 17'(attempts_left), 17'h2);
    $display("walk done");
  endtask

  task t_exhaust;
    retrip = 1'b1;
    trip_up(0);
    cyc(60);
    check("over", 17'(exceeded), 17'h1);
    check("left0", 17'(attempts_left), 17'h0);
    check("num2", 17'(attempt_num), 17'h2);
    cyc(20);
    check("hold", 17'(dout[2]), 17'h1);
    retrip = 1'b0;
    poke(1);
    poke(2);
    cyc(3);
    check("exit", 17'(exceeded), 17'h0);
    check("reinit", 17'(attempts_left), 17'h2);
    attempts_set = 4'hf;
    cyc(2);
    check("clamp", 17'(attempts_left), 17'(ATT_MAX));
    attempts_set = 4'h2;
    $display("exhaust done");
  endtask

  task t_abandon;
    // A long delay keeps the retry pending while each abort is applied.
    delay_set = 13'h0005;
    ctrl_mode = MODE_TWO;
    start_cmd = 1'b1;
    wait_ev(1, 5);
    check("edge", 17'(got), 17'h1);
    trip_up(1);
    start_cmd = 1'b0;
    cyc(3);
    check("drop", 17'(pending), 17'h0);
    for (int m = 2; m < 4; m++) begin
      ctrl_mode = 2'(m);
      trip_up(1);
      poke(2);
      cyc(2);
      check("stop", 17'(pending), 17'h0);
    end
    ctrl_mode = MODE_PROG;
    trip_up(0);
    ext_reset = 1'b1;
    wait_ev(1, 5);
    ext_reset = 1'b0;
    check("rst_in", 17'(got), 17'h1);
    cyc(3);
    check("ext", 17'(pending), 17'h0);
    trip_up(1);
    hand_sel = 1'b1;
    cyc(3);
    check("hand", 17'(pending), 17'h0);
    check("hnum", 17'(attempt_num), 17'h0);
    hand_sel = 1'b0;
    $display("abandon done");
  endtask

  task t_power;
    ctrl_mode = MODE_TWO;
    start_cmd = 1'b1;
    delay_set = 13'h0002;
    attempts_set = 4'h3;
    cyc(4);
    trip_up(0);
    outage_s = 17'h00003;
    poke(4);
    cyc(6);
    check("go_on", 17'(exceeded), 17'h0);
    check("used", 17'(attempts_left inside {4'h1, 4'h2}), 17'h1);
    outage_s = 17'h00007;
    poke(4);
    cyc(3);
    check("long", 17'(exceeded), 17'h1);
    poke(1);
    poke(2);
    ctrl_mode = MODE_THREE;
    start_cmd = 1'b0;
    trip_up(1);
    outage_s = 17'h00001;
    poke(4);
    cyc(3);
    check("saved", 17'(pending), 17'h0);
    trip_up(1);
    start_saved = 1'b1;
    poke(4);
    cyc(3);
    check("resume", 17'(attempts_left), 17'h2);
    start_saved = 1'b0;
    $display("power done");
  endtask

  task close_out;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    cyc(20);
    check("rst", 17'(attempts_left), 17'h0);
    rst_b = 1'b1;
    cyc(3);
    t_walk();
    t_exhaust();
    t_abandon();
    t_power();
    close_out();
  end
endmodule
